// ### test/irr_exec_assertions.sv
// Checker for the return and rotate execution unit
`timescale 1ns/1ps
`default_nettype none
module irr_exec_chk
    import irr_pkg::*;
(
    input wire logic clk, rst, return_from_interrupt_op, rotate_left_op, busy, done, stack_pop,
    input wire logic int_pending, int_ack, master_interrupt_enable, mem_rd, mem_wr, flags_we, stack_push,
    input wire logic [PC_W-1:0]   stack_top, int_vector, pc, stack_push_data,
    input wire logic [ADDR_W-1:0] op_addr, mem_addr,
    input wire logic [DATA_W-1:0] mem_rdata, mem_wdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic r = return_from_interrupt_op && !busy;
    wire logic t = rotate_left_op && !return_from_interrupt_op && !busy;
    property p_pc; r && !int_pending |=> stack_pop && pc == $past(stack_top); endproperty
    a_pc: assert property (p_pc) else $error("pc not popped");
    property p_en; r && !int_pending |=> master_interrupt_enable && done; endproperty
    a_en: assert property (p_en) else $error("enable not set");
    property p_int; r && int_pending |=> int_ack && pc == $past(int_vector); endproperty
    a_int: assert property (p_int) else $error("pending not taken");
    property p_push;
        r && int_pending |=> stack_push && stack_pop && done && stack_push_data == $past(stack_top);
    endproperty
    a_push: assert property (p_push) else $error("return address not pushed");
    property p_rfl; r |=> !flags_we; endproperty
    a_rfl: assert property (p_rfl) else $error("flags written");
    property p_b0; mem_wr |-> mem_wdata[0] == $past(mem_rdata[7]); endproperty
    a_b0: assert property (p_b0) else $error("bit 0 wrong");
    property p_up; mem_wr |-> mem_wdata[7:1] == $past(mem_rdata[6:0]); endproperty
    a_up: assert property (p_up) else $error("upper bits wrong");
    property p_wb; mem_rd |=> mem_wr && $stable(mem_addr) ##1 done && !busy; endproperty
    a_wb: assert property (p_wb) else $error("write back wrong");
    property p_rd; t |=> mem_rd && mem_addr == $past(op_addr); endproperty
    a_rd: assert property (p_rd) else $error("read address wrong");
    property p_rfl8; t |-> !flags_we [*4]; endproperty
    a_rfl8: assert property (p_rfl8) else $error("flags written");
endmodule : irr_exec_chk
bind irr_exec irr_exec_chk i_chk (.*);
`default_nettype wire

// ### test/irr_exec_bench.sv
// Self-checking bench for the return and rotate execution unit
`timescale 1ns/1ps
`default_nettype none
module irr_exec_bench
    import irr_pkg::*;
;
    logic clk = 0, rst = 1, return_from_interrupt_op = 0, rotate_left_op = 0, int_pending = 0, int_disable = 0;
    logic [ADDR_W-1:0] op_addr = 8'h00, mem_addr;
    logic [DATA_W-1:0] mem_rdata = 8'h00, mem_wdata;
    logic [PC_W-1:0]   stack_top = 13'h0000, int_vector = 13'h0000, pc, stack_push_data;
    logic busy, done, stack_pop, int_ack, stack_push, mem_rd, mem_wr, master_interrupt_enable, flags_we;
    logic [15:0] q[$];
    int err_count = 0, total_checks = 0;
    irr_exec i_dut (
        .clk                     (clk),
        .rst                     (rst),
        .return_from_interrupt_op(return_from_interrupt_op),
        .rotate_left_op          (rotate_left_op),
        .op_addr                 (op_addr),
        .busy                    (busy),
        .done                    (done),
        .stack_pop               (stack_pop),
        .stack_top               (stack_top),
        .int_pending             (int_pending),
        .int_vector              (int_vector),
        .int_ack                 (int_ack),
        .stack_push              (stack_push),
        .stack_push_data         (stack_push_data),
        .mem_rd                  (mem_rd),
        .mem_wr                  (mem_wr),
        .mem_addr                (mem_addr),
        .mem_wdata               (mem_wdata),
        .mem_rdata               (mem_rdata),
        .pc                      (pc),
        .master_interrupt_enable (master_interrupt_enable),
        .int_disable             (int_disable),
        .flags_we                (flags_we)
    );
    always #4 clk = ~clk;
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task chk(input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask : chk
    task close_out;
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    always @(negedge clk) begin
        if (!rst && (mem_wr || stack_pop))
            chk(mem_wr ? {mem_addr, mem_wdata} : {stack_push, master_interrupt_enable, int_ack, pc}, q.pop_front());
        if (!rst && (busy || done)) chk({15'h0, flags_we}, 16'h0000);
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task op(input logic rot);
        logic [7:0] a, d;
        logic [12:0] t, v;
        logic p;
        a = $urandom;
        d = $urandom;
        t = $urandom;
        v = $urandom;
        p = $urandom;
        @(posedge clk);
        return_from_interrupt_op <= !rot;
        rotate_left_op <= rot | 1'($urandom);
        {op_addr, mem_rdata, stack_top, int_vector, int_pending, int_disable} <= {a, d, t, v, p, 1'($urandom)};
        q.push_back(rot ? {a, d[6:0], d[7]} : (p ? {3'h5, v} : {3'h2, t}));
        @(posedge clk);
        return_from_interrupt_op <= rot ? 1'($urandom) : 1'b0;
        rotate_left_op <= 0;
        if (rot) begin
            @(posedge clk);
            return_from_interrupt_op <= 1'($urandom);
            @(posedge clk);
            return_from_interrupt_op <= 1'b0;
        end
    endtask : op
    initial begin
        void'($urandom(32'h4194));
        repeat (16) @(posedge clk);
        rst <= 0;
        repeat (150) op(1'($urandom));
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        chk({1'b0, busy, master_interrupt_enable, pc}, {3'h0, PC_RESET});
        repeat (150) op(1'($urandom));
        repeat (4) @(posedge clk);
        chk(16'(q.size()), 16'h0000);
        close_out;
    end
    initial begin
        #20000;
        err_count++;
        close_out;
    end
endmodule : irr_exec_bench
`default_nettype wire

// ### verilog/irr_exec.sv
// Execution unit for the return-from-interrupt and in-place rotate-left instructions
//
// Function
// - Return loads PC from popped stack top when no interrupt is pending.
// - Return sets master interrupt enable to one, or clears it if an interrupt is pending.
// - Pending interrupt serviced before main program resumes.
// - Return leaves every status flag unchanged.
// - Rotate moves bit seven into bit zero.
// - Rotate moves bits zero..six up one.
// - Rotate writes back same address, one position.
// - Rotate changes no status flag, carry included.
`timescale 1ns/1ps
`default_nettype none
module irr_exec
    import irr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Instruction issue
    input  wire logic              return_from_interrupt_op,
    input  wire logic              rotate_left_op,
    input  wire logic [ADDR_W-1:0] op_addr,
    output logic                   busy,
    output logic                   done,
    // Hardware return stack
    output logic                   stack_pop,
    input  wire logic [PC_W-1:0]   stack_top,
    // Interrupt controller
    input  wire logic              int_pending,
    input  wire logic [PC_W-1:0]   int_vector,
    output logic                   int_ack,
    output logic                   stack_push,
    output logic [PC_W-1:0]        stack_push_data,
    // Data memory
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    input  wire logic [DATA_W-1:0] mem_rdata,
    // Core state
    output logic [PC_W-1:0]        pc,
    output logic                   master_interrupt_enable,
    input  wire logic              int_disable,
    output logic                   flags_we
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    irr_state_t        state_reg, state_next;
    logic [PC_W-1:0]   pc_reg, pc_next;
    logic              mie_reg, mie_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic              done_reg, done_next;
    logic              pop_reg, pop_next;
    logic              push_reg, push_next;
    logic              ack_reg, ack_next;
    logic [PC_W-1:0]   push_data_reg, push_data_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        pc_next        = pc_reg;
        mie_next       = mie_reg;
        addr_next      = addr_reg;
        wdata_next     = wdata_reg;
        done_next      = 1'b0;
        pop_next       = 1'b0;
        push_next      = 1'b0;
        ack_next       = 1'b0;
        push_data_next = push_data_reg;
        if (int_disable) begin
            mie_next = 1'b0;
        end
        case (state_reg)
            IRR_IDLE: begin
                if (return_from_interrupt_op) begin
                    pop_next  = 1'b1;
                    done_next = 1'b1;
                    if (int_pending) begin
                        pc_next        = int_vector;
                        push_next      = 1'b1;
                        push_data_next = stack_top;
                        ack_next       = 1'b1;
                        mie_next       = 1'b0;
                    end else begin
                        pc_next  = stack_top;
                        mie_next = 1'b1;
                    end
                end else if (rotate_left_op) begin
                    addr_next  = op_addr;
                    state_next = IRR_READ;
                end
            end
            IRR_READ: begin
                wdata_next = {mem_rdata[MSB-1:0], mem_rdata[MSB]};
                state_next = IRR_WRITE;
            end
            IRR_WRITE: begin
                done_next  = 1'b1;
                state_next = IRR_IDLE;
            end
            default: begin
                state_next = IRR_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg     <= IRR_IDLE;
            pc_reg        <= PC_RESET;
            mie_reg       <= 1'b0;
            addr_reg      <= '0;
            wdata_reg     <= '0;
            done_reg      <= 1'b0;
            pop_reg       <= 1'b0;
            push_reg      <= 1'b0;
            ack_reg       <= 1'b0;
            push_data_reg <= PC_RESET;
        end else begin
            state_reg     <= state_next;
            pc_reg        <= pc_next;
            mie_reg       <= mie_next;
            addr_reg      <= addr_next;
            wdata_reg     <= wdata_next;
            done_reg      <= done_next;
            pop_reg       <= pop_next;
            push_reg      <= push_next;
            ack_reg       <= ack_next;
            push_data_reg <= push_data_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy                    = (state_reg != IRR_IDLE);
    assign done                    = done_reg;
    assign stack_pop               = pop_reg;
    assign stack_push              = push_reg;
    assign stack_push_data         = push_data_reg;
    assign int_ack                 = ack_reg;
    assign mem_rd                  = (state_reg == IRR_READ);
    assign mem_wr                  = (state_reg == IRR_WRITE);
    assign mem_addr                = addr_reg;
    assign mem_wdata               = wdata_reg;
    assign pc                      = pc_reg;
    assign master_interrupt_enable = mie_reg;
    assign flags_we                = 1'b0;

endmodule : irr_exec
`default_nettype wire

// ### verilog/irr_pkg.sv
// Package for the return-from-interrupt and rotate-left execution block
package irr_pkg;
    localparam int PC_W   = 13;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int MSB    = DATA_W - 1;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR_DEFAULT = 13'h0004;

    typedef enum logic [1:0] {
        IRR_IDLE  = 2'b00,
        IRR_READ  = 2'b01,
        IRR_WRITE = 2'b10
    } irr_state_t;
endpackage : irr_pkg
